// >>> ctx_core_bus.sv
`timescale 1ns/10ps
`default_nettype none
module ctx_core_bus (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic addr_latch_en,
    output logic rd_strobe_n,
    output logic wr_strobe_n,
    output logic [7:0] addr_data_low_port_o,
    output logic [7:0] addr_data_low_port_oe,
    input wire logic [7:0] addr_data_low_port_i,
    output logic [7:0] addr_high_port_o,
    output logic [7:0] addr_high_port_oe,
    input wire logic [7:0] addr_high_port_i
);
    typedef struct packed {
        ctx_pkg::ctx_mv_e mv;
        logic [1:0] phase;
        logic [5:0] cnt;
        logic go;
        logic [7:0] clkctl;
        logic [15:0] dptr0;
        logic [15:0] dptr1;
        logic [1:0] dps;
        logic [1:0] mvctl;
        logic [7:0] wdat;
        logic [7:0] rdat;
        logic done;
        logic ext_mode;
        logic [15:0] gp_out;
        logic [15:0] gp_oe;
        logic [15:0] timer;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic ale;
        logic rd_n;
        logic wr_n;
        logic [7:0] lo_o;
        logic [7:0] lo_oe;
        logic [7:0] hi_o;
        logic [7:0] hi_oe;
    } ctx_st_s;

    ctx_st_s st_r;
    ctx_st_s st_nxt;
    logic tmr_tick;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    // strobe width
    function automatic logic [5:0] strobe_clks(input logic [2:0] sel);
        if (sel == 3'h0) begin
            strobe_clks = 6'(ctx_pkg::STRB_MIN_CLKS);
        end else begin
            strobe_clks = 6'(ctx_pkg::STRB_STEP_CLKS * sel);
        end
    endfunction

    function automatic logic [5:0] move_clks(input logic [2:0] sel);
        move_clks = 6'(ctx_pkg::INSTR_CLKS * (sel + ctx_pkg::MOVE_BASE_CYCLES));
    endfunction

    // ------------------------------------------------------------
    // timer prescaler
    // ------------------------------------------------------------
    ctx_tmr_prescale u_pre (
        .pclk(pclk),
        .presetn(presetn),
        .fast_sel(st_r.clkctl[ctx_pkg::CK_TFAST]),
        .tick(tmr_tick)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic setup;
        logic wr_acc;
        logic [2:0] md;
        logic [15:0] addr;
        logic done_set;
        logic done_clr;
        setup = psel && !penable;
        wr_acc = psel && penable && st_r.pready && pwrite;
        md = st_r.clkctl[ctx_pkg::CK_MD_MSB:ctx_pkg::CK_MD_LSB];
        addr = st_r.dps[ctx_pkg::DPS_SEL] ? st_r.dptr1 : st_r.dptr0;
        done_set = 1'b0;
        done_clr = 1'b0;
        st_nxt = st_r;

        // instruction phase
        // phase runs on pclk itself, no divider in front of the core
        st_nxt.phase = (st_r.phase == 2'(ctx_pkg::INSTR_CLKS - 1)) ? 2'h0 : st_r.phase + 2'h1;

        if (tmr_tick) begin
            st_nxt.timer = st_r.timer + 16'h0001;
        end

        // ---------------- external data move engine ----------------
        st_nxt.cnt = st_r.cnt + 6'h01;
        case (st_r.mv)
            ctx_pkg::MV_IDLE: begin
                st_nxt.cnt = 6'h00;
                // moves start on an instruction cycle boundary
                if (st_r.go && st_r.phase == 2'(ctx_pkg::INSTR_CLKS - 1)) begin
                    st_nxt.go = 1'b0;
                    st_nxt.mv = ctx_pkg::MV_ADDR;
                    st_nxt.ale = 1'b1;
                    st_nxt.lo_o = addr[7:0];
                    st_nxt.lo_oe = 8'hFF;
                    st_nxt.hi_o = addr[15:8];
                    st_nxt.hi_oe = 8'hFF;
                end
            end
            ctx_pkg::MV_ADDR: begin
                // low byte held past the pulse
                if (st_r.cnt == 6'(ctx_pkg::ALE_CLKS - 1)) begin
                    st_nxt.ale = 1'b0;
                end
                if (st_r.cnt == 6'(ctx_pkg::STRB_START - 1)) begin
                    st_nxt.mv = ctx_pkg::MV_STRB;
                    if (st_r.mvctl[ctx_pkg::MV_WRITE]) begin
                        st_nxt.wr_n = 1'b0;
                        st_nxt.lo_o = st_r.wdat;
                    end else begin
                        st_nxt.rd_n = 1'b0;
                        st_nxt.lo_oe = 8'h00;   // hand the port to the memory
                    end
                end
            end
            ctx_pkg::MV_STRB: begin
                if (st_r.cnt == 6'(ctx_pkg::STRB_START) + strobe_clks(md) - 6'h01) begin
                    st_nxt.mv = ctx_pkg::MV_TAIL;
                    st_nxt.rd_n = 1'b1;
                    st_nxt.wr_n = 1'b1;
                    if (!st_r.mvctl[ctx_pkg::MV_WRITE]) begin
                        st_nxt.rdat = addr_data_low_port_i;
                    end
                end
            end
            ctx_pkg::MV_TAIL: begin
                if (st_r.cnt == move_clks(md) - 6'h01) begin
                    st_nxt.mv = ctx_pkg::MV_IDLE;
                    st_nxt.lo_oe = 8'h00;
                    done_set = 1'b1;
                    // pointer wraps like the classic increment
                    if (st_r.mvctl[ctx_pkg::MV_INC]) begin
                        if (st_r.dps[ctx_pkg::DPS_SEL]) begin
                            st_nxt.dptr1 = st_r.dptr1 + 16'h0001;
                        end else begin
                            st_nxt.dptr0 = st_r.dptr0 + 16'h0001;
                        end
                    end
                    if (st_r.dps[ctx_pkg::DPS_TOGGLE]) begin
                        st_nxt.dps[ctx_pkg::DPS_SEL] = !st_r.dps[ctx_pkg::DPS_SEL];
                    end
                end
            end
            default: begin
                st_nxt.mv = ctx_pkg::MV_IDLE;
            end
        endcase

        // port mode
        // gpio drive only while idle, so a mode change never cuts a move short
        if (st_nxt.mv == ctx_pkg::MV_IDLE) begin
            st_nxt.ale = 1'b0;
            st_nxt.rd_n = 1'b1;
            st_nxt.wr_n = 1'b1;
            if (!st_r.ext_mode) begin
                st_nxt.lo_o = st_r.gp_out[7:0];
                st_nxt.lo_oe = st_r.gp_oe[7:0];
                st_nxt.hi_o = st_r.gp_out[15:8];
                st_nxt.hi_oe = st_r.gp_oe[15:8];
            end else begin
                // bus mode idle: high port keeps driving, even after gpio mode
                st_nxt.lo_oe = 8'h00;
                st_nxt.hi_oe = 8'hFF;
            end
        end

        // ---------------- apb read path, answered next cycle ----------------
        st_nxt.pready = setup;
        st_nxt.pslverr = 1'b0;
        st_nxt.prdata = 32'h0000_0000;
        if (setup) begin
            case (paddr)
                ctx_pkg::A_CLKCTL: st_nxt.prdata = {24'h000000, st_r.clkctl};
                ctx_pkg::A_DPTR0: st_nxt.prdata = {16'h0000, st_r.dptr0};
                ctx_pkg::A_DPTR1: st_nxt.prdata = {16'h0000, st_r.dptr1};
                ctx_pkg::A_DPSEL: st_nxt.prdata = {30'h00000000, st_r.dps};
                ctx_pkg::A_MOVE: st_nxt.prdata = {30'h00000000, st_r.mvctl};
                ctx_pkg::A_DATA: st_nxt.prdata = {24'h000000, st_r.rdat};
                ctx_pkg::A_STAT: begin
                    st_nxt.prdata = {30'h00000000, st_r.done,
                                     st_r.go || st_r.mv != ctx_pkg::MV_IDLE};
                end
                ctx_pkg::A_BUSCFG: st_nxt.prdata = {31'h00000000, st_r.ext_mode};
                ctx_pkg::A_GPOUT: st_nxt.prdata = {16'h0000, st_r.gp_out};
                ctx_pkg::A_GPOE: st_nxt.prdata = {16'h0000, st_r.gp_oe};
                ctx_pkg::A_GPIN: begin
                    st_nxt.prdata = {16'h0000, addr_high_port_i, addr_data_low_port_i};
                end
                ctx_pkg::A_TIMER: st_nxt.prdata = {16'h0000, st_r.timer};
                default: st_nxt.pslverr = 1'b1;
            endcase
        end

        // ---------------- apb writes ----------------
        if (wr_acc) begin
            case (paddr)
                ctx_pkg::A_CLKCTL: st_nxt.clkctl = pwdata[7:0];
                ctx_pkg::A_DPTR0: st_nxt.dptr0 = pwdata[15:0];
                ctx_pkg::A_DPTR1: st_nxt.dptr1 = pwdata[15:0];
                ctx_pkg::A_DPSEL: st_nxt.dps = pwdata[1:0];
                ctx_pkg::A_MOVE: begin
                    // a start while busy is dropped, the move in flight owns the bus
                    if (!st_r.go && st_r.mv == ctx_pkg::MV_IDLE && st_r.ext_mode) begin
                        st_nxt.mvctl = pwdata[1:0];
                        st_nxt.go = 1'b1;
                    end
                end
                ctx_pkg::A_DATA: st_nxt.wdat = pwdata[7:0];
                ctx_pkg::A_STAT: done_clr = pwdata[ctx_pkg::ST_DONE];
                ctx_pkg::A_BUSCFG: st_nxt.ext_mode = pwdata[0];
                ctx_pkg::A_GPOUT: st_nxt.gp_out = pwdata[15:0];
                ctx_pkg::A_GPOE: st_nxt.gp_oe = pwdata[15:0];
                ctx_pkg::A_TIMER: st_nxt.timer = pwdata[15:0];
                default: st_nxt.done = st_r.done;
            endcase
        end

        // done is write-one-to-clear; a completion in the same cycle wins
        st_nxt.done = done_set || (st_r.done && !done_clr);
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
            st_r.mv <= ctx_pkg::MV_IDLE;
            st_r.clkctl <= ctx_pkg::CLKCTL_RST;
            st_r.ext_mode <= ctx_pkg::BUSCFG_RST;
            st_r.rd_n <= 1'b1;
            st_r.wr_n <= 1'b1;
            st_r.hi_oe <= 8'hFF;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs, all straight from the state register
    // ------------------------------------------------------------
    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign addr_latch_en = st_r.ale;
    assign rd_strobe_n = st_r.rd_n;
    assign wr_strobe_n = st_r.wr_n;
    assign addr_data_low_port_o = st_r.lo_o;
    assign addr_data_low_port_oe = st_r.lo_oe;
    assign addr_high_port_o = st_r.hi_o;
    assign addr_high_port_oe = st_r.hi_oe;
endmodule
`default_nettype wire

// >>> ctx_pkg.sv
package ctx_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int INSTR_CLKS = 4;          // system clocks per instruction cycle
    localparam int CLASSIC_CLKS = 12;       // classic core, also slow timer rate
    localparam int TMR_SLOW_CLKS = 12;
    localparam int TMR_FAST_CLKS = 4;
    localparam int MOVE_BASE_CYCLES = 2;    // move cycles = stretch + this
    localparam int STRB_MIN_CLKS = 2;       // strobe width at stretch 0
    localparam int STRB_STEP_CLKS = 4;      // strobe width per stretch step
    localparam int ALE_CLKS = 2;            // address latch pulse length
    localparam int STRB_START = 4;          // clock of the move where strobe falls

    // ------------------------------------------------------------
    // register map (byte addresses on the bus)
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] CLKCTL_INDEX = 12'h08E;
    localparam logic [ADDR_W-1:0] A_CLKCTL = 12'h238;     // index times four
    localparam logic [ADDR_W-1:0] A_DPTR0 = 12'h000;
    localparam logic [ADDR_W-1:0] A_DPTR1 = 12'h004;
    localparam logic [ADDR_W-1:0] A_DPSEL = 12'h008;
    localparam logic [ADDR_W-1:0] A_MOVE = 12'h00C;
    localparam logic [ADDR_W-1:0] A_DATA = 12'h010;
    localparam logic [ADDR_W-1:0] A_STAT = 12'h014;
    localparam logic [ADDR_W-1:0] A_BUSCFG = 12'h018;
    localparam logic [ADDR_W-1:0] A_GPOUT = 12'h01C;
    localparam logic [ADDR_W-1:0] A_GPOE = 12'h020;
    localparam logic [ADDR_W-1:0] A_GPIN = 12'h024;
    localparam logic [ADDR_W-1:0] A_TIMER = 12'h028;

    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int CK_MD_LSB = 0;
    localparam int CK_MD_MSB = 2;
    localparam int CK_TFAST = 3;
    localparam logic [7:0] CLKCTL_RST = 8'h01;
    localparam int DPS_SEL = 0;
    localparam int DPS_TOGGLE = 1;
    localparam int MV_WRITE = 0;
    localparam int MV_INC = 1;
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam logic BUSCFG_RST = 1'b1;     // ports start as external bus

    typedef enum logic [3:0] {
        MV_IDLE = 4'h1,
        MV_ADDR = 4'h2,
        MV_STRB = 4'h4,
        MV_TAIL = 4'h8
    } ctx_mv_e;
endpackage

// >>> ctx_tmr_prescale.sv
`timescale 1ns/10ps
`default_nettype none
module ctx_tmr_prescale (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic fast_sel,
    output logic tick
);
    typedef struct packed {
        logic [3:0] cnt;
        logic tick;
    } ctx_pre_s;

    ctx_pre_s st_r;
    ctx_pre_s st_nxt;

    // ------------------------------------------------------------
    // divider: one pulse per 12 clocks, or per 4 when fast
    // ------------------------------------------------------------
    // prescale divide
    always_comb begin
        logic [3:0] last;
        last = fast_sel ? 4'(ctx_pkg::TMR_FAST_CLKS - 1) : 4'(ctx_pkg::TMR_SLOW_CLKS - 1);
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        // a switch to fast while the count is above 3 wraps at once
        if (st_r.cnt >= last) begin
            st_nxt.cnt = 4'h0;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + 4'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick = st_r.tick;
endmodule
`default_nettype wire

// >>> ctx_core_bus_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// ----
// bus timing checks
// ----
module ctx_core_bus_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic addr_latch_en,
    input wire logic rd_strobe_n,
    input wire logic wr_strobe_n,
    input wire logic [7:0] addr_data_low_port_o,
    input wire logic [7:0] addr_data_low_port_oe,
    input wire logic [7:0] addr_data_low_port_i,
    input wire logic [7:0] addr_high_port_o,
    input wire logic [7:0] addr_high_port_oe,
    input wire logic [7:0] addr_high_port_i
);
    logic [2:0] md_r;
    logic [4:0] st_r;
    logic [4:0] wid;
    logic lo;
    // stretch code mirrored from bus writes, since the register is not visible here
    assign lo = !rd_strobe_n || !wr_strobe_n;
    assign wid = (md_r == 3'h0) ? 5'h02 : {md_r, 2'h0};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            md_r <= 3'h1;
            st_r <= 5'h00;
        end else begin
            if (psel && penable && pready && pwrite && paddr == ctx_pkg::A_CLKCTL) begin
                md_r <= pwdata[2:0];
            end
            st_r <= lo ? st_r + 5'h01 : 5'h00;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ale_pulse_a: assert property (
        $rose(addr_latch_en) |=> addr_latch_en ##1 !addr_latch_en) else $error("latch width");
    ale_addr_a: assert property (
        addr_latch_en |-> addr_data_low_port_oe == 8'hFF && !lo) else $error("latch addr");
    strb_start_a: assert property (
        $fell(addr_latch_en) |-> !lo ##1 !lo ##1 lo) else $error("strobe start");
    strb_width_a: assert property (
        $fell(lo) |-> st_r == wid) else $error("strobe width");
    rd_release_a: assert property (
        !rd_strobe_n |-> addr_data_low_port_oe == 8'h00) else $error("read drive");
    wr_drive_a: assert property (
        !wr_strobe_n |-> addr_data_low_port_oe == 8'hFF) else $error("write drive");
    hi_hold_a: assert property (
        lo |-> $stable(addr_high_port_o) && addr_high_port_oe == 8'hFF) else $error("high addr");
    apb_ready_a: assert property (
        psel && !penable |=> pready ##1 !pready) else $error("ready timing");
    cover property ($fell(lo) && md_r == 3'h7);
    cover property (!wr_strobe_n);
    cover property (pslverr);
endmodule
bind ctx_core_bus ctx_core_bus_asserts i_chk (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .addr_latch_en, .rd_strobe_n, .wr_strobe_n, .addr_data_low_port_o,
    .addr_data_low_port_oe, .addr_data_low_port_i, .addr_high_port_o,
    .addr_high_port_oe, .addr_high_port_i
);
`default_nettype wire

// >>> ctx_ext_mem.sv
`timescale 1ns/10ps
`default_nettype none
// ----
// external data memory
// ----
module ctx_ext_mem (
    input wire logic pclk,
    input wire logic [4:0] dly,
    input wire logic ale,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [7:0] lo_o,
    input wire logic [7:0] lo_oe,
    input wire logic [7:0] hi_o,
    output logic [7:0] lo_i
);
    logic [7:0] mem [logic [15:0]];
    logic [15:0] a_r = 16'h0000;
    logic [7:0] q_r = 8'h00;
    logic [4:0] n_r = 5'h00;
    // low byte taken during latch pulse
    always @(posedge pclk) begin
        if (ale) begin
            a_r <= {hi_o, lo_o};
        end
        n_r <= rd_n ? 5'h00 : n_r + 5'h01;
        q_r <= mem.exists(a_r) ? mem[a_r] : 8'h00;
    end
    // write taken as the strobe ends; oe guard skips the reset edge
    always @(posedge wr_n) begin
        if (lo_oe === 8'hFF) begin
            mem[a_r] = lo_o;
        end
    end
    // slow device answers after dly strobe clocks; a floating line shows garbage
    assign lo_i = (!rd_n && n_r >= dly) ? q_r : lo_o ^ ~lo_oe;
endmodule
`default_nettype wire

// >>> tb_core_timing_ext_data_bus.sv
`timescale 1ns/10ps
`default_nettype none
module tb_core_timing_ext_data_bus;
    typedef struct packed {
        logic [2:0] md;
        logic [4:0] dly;
        logic [15:0] a;
        logic [7:0] d;
        logic [4:0] w;
    } ctx_row_s;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdat;
    logic pready, pslverr, rerr, ale, rd_n, wr_n;
    logic ale_q = 1'b0;
    logic [7:0] lo_o, lo_oe, lo_i, hi_o, hi_oe, hi_i;
    logic [4:0] dly = 5'h01;
    logic [4:0] sc = 5'h00;
    logic [4:0] w_seen = 5'h00;
    int cyc = 0, t_ale = 0, n_ale = 0, el, k0, tcl, n_errors = 0, cmp_count = 0;
    ctx_row_s rows [8] = '{'{3'h0, 5'h01, 16'h0000, 8'h5A, 5'h02},
        '{3'h1, 5'h03, 16'hFFFF, 8'hA5, 5'h04}, '{3'h2, 5'h00, 16'h00FF, 8'h3C, 5'h08},
        '{3'h3, 5'h0B, 16'hFF00, 8'hC3, 5'h0C}, '{3'h4, 5'h02, 16'h1234, 8'h01, 5'h10},
        '{3'h5, 5'h13, 16'h8001, 8'h80, 5'h14}, '{3'h6, 5'h05, 16'h7FFE, 8'hFF, 5'h18},
        '{3'h7, 5'h1B, 16'hA55A, 8'h69, 5'h1C}};
    // released high port shows the inverse of what was last driven
    assign hi_i = hi_o ^ ~hi_oe;
    ctx_core_bus i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .addr_latch_en(ale), .rd_strobe_n(rd_n), .wr_strobe_n(wr_n),
        .addr_data_low_port_o(lo_o), .addr_data_low_port_oe(lo_oe),
        .addr_data_low_port_i(lo_i), .addr_high_port_o(hi_o), .addr_high_port_oe(hi_oe),
        .addr_high_port_i(hi_i));
    ctx_ext_mem i_mem (.pclk(pclk), .dly(dly), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
        .lo_o(lo_o), .lo_oe(lo_oe), .hi_o(hi_o), .lo_i(lo_i));
    // ----
    // clock, pin monitor, watchdog
    // ----
    initial begin
        forever #5 pclk = ~pclk;
    end
    // latch start time and strobe width as seen on the pins
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        ale_q <= ale;
        if (ale && !ale_q) begin
            t_ale <= cyc;
            n_ale <= n_ale + 1;
        end
        sc <= (!rd_n || !wr_n) ? sc + 5'h01 : 5'h00;
        if (rd_n && wr_n && sc != 5'h00) begin
            w_seen <= sc;
        end
    end
    initial begin
        repeat (10000) @(posedge pclk);
        n_errors++;
        stop_test();
    end
    // ----
    // tasks
    // ----
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one transfer; holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        do begin
            @(posedge pclk);
            penable <= 1'b1;
            n++;
        end while (!(penable && pready === 1'b1) && n < 20);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) n_errors++;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    // poll for done, note the move length, then clear done
    task automatic wdone();
        int k;
        k = 0;
        do begin
            rd(ctx_pkg::A_STAT);
            k++;
        end while (rdat[ctx_pkg::ST_DONE] !== 1'b1 && k < 40);
        if (k >= 40) n_errors++;
        el = cyc - t_ale;
        wr(ctx_pkg::A_STAT, 32'h2);
    endtask
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ----
    // tests
    // ----
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            dly <= rows[i].dly;
            tcl = (rows[i].md + ctx_pkg::MOVE_BASE_CYCLES) * ctx_pkg::INSTR_CLKS;
            wr(ctx_pkg::A_CLKCTL, 32'(rows[i].md));
            wr(ctx_pkg::A_DPTR0, 32'(rows[i].a));
            wr(ctx_pkg::A_DATA, 32'(rows[i].d));
            for (int r = 0; r < 2; r++) begin
                wr(ctx_pkg::A_MOVE, r ? 32'h0 : 32'h1);
                wdone();
                chk(32'(w_seen), 32'(rows[i].w));
                chk(32'(el >= tcl && el <= tcl + 3), 32'h1);
            end
            chk(32'(i_mem.mem[rows[i].a]), 32'(rows[i].d));
            rd(ctx_pkg::A_DATA);
            chk(32'(rdat[7:0]), 32'(rows[i].d));
            $display("stretch row %0d done", i);
        end
        k0 = n_ale;
        wr(ctx_pkg::A_CLKCTL, 32'h1);
        wr(ctx_pkg::A_DPTR0, 32'h0100);
        wr(ctx_pkg::A_DPTR1, 32'h0200);
        wr(ctx_pkg::A_DPSEL, 32'h2);
        wr(ctx_pkg::A_DATA, 32'h11);
        wr(ctx_pkg::A_MOVE, 32'h3);
        wr(ctx_pkg::A_MOVE, 32'h3);
        wdone();
        wr(ctx_pkg::A_DATA, 32'h22);
        wr(ctx_pkg::A_MOVE, 32'h1);
        wdone();
        chk(32'(n_ale), 32'(k0 + 2));
        chk(32'(i_mem.mem[16'h0100]), 32'h11);
        chk(32'(i_mem.mem[16'h0200]), 32'h22);
        rd(ctx_pkg::A_DPTR0);
        chk(rdat, 32'h0101);
        rd(ctx_pkg::A_DPSEL);
        chk(rdat, 32'h2);
        $display("dual pointer test done");
        k0 = n_ale;
        wr(ctx_pkg::A_BUSCFG, 32'h0);
        wr(ctx_pkg::A_GPOE, 32'hFFFF);
        wr(ctx_pkg::A_GPOUT, 32'hC35A);
        wr(ctx_pkg::A_MOVE, 32'h1);
        repeat (4) @(posedge pclk);
        rd(ctx_pkg::A_GPIN);
        chk(rdat, 32'hC35A);
        chk({hi_oe, lo_oe, hi_o, lo_o}, 32'hFFFFC35A);
        wr(ctx_pkg::A_GPOE, 32'h0);
        repeat (4) @(posedge pclk);
        rd(ctx_pkg::A_GPIN);
        chk(rdat, 32'h3CA5);
        chk(32'(n_ale), 32'(k0));
        wr(ctx_pkg::A_BUSCFG, 32'h1);
        rd(12'hFFC);
        chk(32'(rerr), 32'h1);
        $display("port mode test done");
        for (int f = 0; f < 2; f++) begin
            wr(ctx_pkg::A_CLKCTL, f ? 32'h9 : 32'h1);
            wr(ctx_pkg::A_TIMER, 32'h0);
            k0 = cyc;
            repeat (120) @(posedge pclk);
            rd(ctx_pkg::A_TIMER);
            tcl = (cyc - k0) / (f ? ctx_pkg::TMR_FAST_CLKS : ctx_pkg::TMR_SLOW_CLKS);
            chk(32'(rdat + 1 >= tcl && rdat <= tcl + 1), 32'h1);
        end
        $display("timer rate test done");
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(ctx_pkg::A_CLKCTL);
        chk(rdat, 32'h1);
        rd(ctx_pkg::A_BUSCFG);
        chk(rdat, 32'h1);
        wr(ctx_pkg::A_MOVE, 32'h1);
        wdone();
        chk(32'(w_seen), 32'h4);
        chk(32'(el >= 12 && el <= 15), 32'h1);
        $display("reset test done");
        stop_test();
    end
endmodule
`default_nettype wire
